// ==== logic/mrt_pkg.sv ====
/*
 * mrt_pkg: command codes, timing figures and derived spacing counts
 * shared by the controller end and the memory end of the mode register link.
 * assumes a 25 MHz command clock; latencies are plain defaults.
 */
`default_nettype none
package mrt_pkg;
	// ****************************************************
	// command encoding on the link
	// ****************************************************
	typedef enum logic [3:0] {
		MRT_DES = 4'h0, MRT_ACT = 4'h1, MRT_PRE = 4'h2, MRT_RD = 4'h3,
		MRT_RDA = 4'h4, MRT_WR = 4'h5, MRT_WRA = 4'h6, MRT_MRR = 4'h7,
		MRT_MRW = 4'h8, MRT_PDX = 4'h9
	} mrt_cmd_type;

	// ****************************************************
	// clock and latency figures
	// ****************************************************
	localparam int TCK_PS = 40000;      // clock period in ps
	localparam int RL_CK = 6;           // read latency
	localparam int WL_CK = 4;           // write latency
	localparam int BL_CK = 16;          // burst length
	localparam int DQSCK_MAX_PS = 3600; // read strobe skew, rounded up
	localparam int TWPRE_CK = 2;        // write preamble
	localparam int RPST_RD_CK = 0;      // read postamble, rounded down
	localparam int ODTLON_CK = 2;       // termination on latency
	localparam int ODTON_RD_CK = 0;     // termination on time, rounded down
	localparam int TWTR_PS = 10000;     // write to read turn-around
	localparam int NRTP_CK = 8;         // read to precharge
	localparam int NWR_CK = 6;          // write recovery
	localparam int TXP_CK = 5;          // power-down exit
	localparam int TRCD_CK = 5;         // activate to column
	localparam int TMRR_CK = 8;         // mode register read period
	localparam int TMRW_PS = 10000;     // mode register write period, time part
	localparam int TMRD_PS = 14000;     // mode register set delay, time part
	localparam int TMR_MIN_CK = 10;     // clock part of both periods above
	localparam int HOLD_PS = 7500;      // settle time before a write
	localparam int HOLD_MIN_CK = 8;
	localparam int HC_ENABLE_NS = 200;  // high_current_enable_time, longest
	localparam int HC_DISABLE_NS = 100; // high_current_disable_time, longest

	// ****************************************************
	// derived counts (least times round up, longest round down)
	// ****************************************************
	localparam int DQSCK_CK = (DQSCK_MAX_PS + TCK_PS - 1) / TCK_PS;
	localparam int TWTR_CK = (TWTR_PS + TCK_PS - 1) / TCK_PS;
	localparam int TMRW_RU = (TMRW_PS + TCK_PS - 1) / TCK_PS;
	localparam int TMRD_RU = (TMRD_PS + TCK_PS - 1) / TCK_PS;
	localparam int TMRW_CK = (TMRW_RU > TMR_MIN_CK) ? TMRW_RU : TMR_MIN_CK;
	localparam int TMRD_CK = (TMRD_RU > TMR_MIN_CK) ? TMRD_RU : TMR_MIN_CK;
	localparam int HOLD_RU = (HOLD_PS + TCK_PS - 1) / TCK_PS;
	localparam int HOLD_CK = (HOLD_RU > HOLD_MIN_CK) ? HOLD_RU : HOLD_MIN_CK;
	localparam int TMRRI_CK = TRCD_CK + 3;
	localparam int HC_EN_RAW = HC_ENABLE_NS * 1000 / TCK_PS;
	localparam int HC_DIS_RAW = HC_DISABLE_NS * 1000 / TCK_PS;
	localparam int HC_EN_CK = (HC_EN_RAW < 1) ? 1 : HC_EN_RAW;
	localparam int HC_DIS_CK = (HC_DIS_RAW < 1) ? 1 : HC_DIS_RAW;

	// ****************************************************
	// least spacing between commands, in clock cycles
	// ****************************************************
	localparam int G_MRR_WR = RL_CK + DQSCK_CK + BL_CK / 2 - WL_CK + TWPRE_CK + RPST_RD_CK;
	localparam int G_MRR_WR_ODT = RL_CK + DQSCK_CK + BL_CK / 2 - ODTLON_CK - ODTON_RD_CK
		+ RPST_RD_CK + 1;
	localparam int G_MRR_MRW = RL_CK + DQSCK_CK + BL_CK / 2 + 3;
	localparam int G_RD_MRR = BL_CK / 2;
	localparam int G_WR_MRR = WL_CK + 1 + BL_CK / 2 + TWTR_CK;
	localparam int G_PDX_MRR = TXP_CK + TMRRI_CK;
	localparam int G_RD_MRW = RL_CK + BL_CK / 2 + DQSCK_CK + RPST_RD_CK + HOLD_CK;
	localparam int G_RDA_MRW = G_RD_MRW + NRTP_CK - 8;
	localparam int G_WR_MRW = WL_CK + 1 + BL_CK / 2 + HOLD_CK;
	localparam int G_WRA_MRW = G_WR_MRW + NWR_CK;

	// ****************************************************
	// history slots and mode register layout
	// ****************************************************
	localparam int NKIND = 7;           // MRR, MRW, RD, RDA, WR, WRA, PDX
	localparam int K_MRR = 0;
	localparam int K_MRW = 1;
	localparam int K_RD = 2;
	localparam int K_RDA = 3;
	localparam int K_WR = 4;
	localparam int K_WRA = 5;
	localparam int K_PDX = 6;
	localparam int CNT_W = 8;           // saturating age counters
	localparam int NMR = 64;            // mode register count
	localparam logic [5:0] MR_CA_VREF = 6'h0c;
	localparam logic [5:0] MR_HC_CTRL = 6'h0d;
	localparam logic [5:0] MR_DQ_VREF = 6'h0e;
	localparam int HC_BIT = 3;          // position of high_current_mode_bit
	localparam logic [7:0] MR_RESET = 8'h00;
endpackage
`default_nettype wire

// ==== logic/mrt_link_if.sv ====
/*
 * mrt_link_if: command/address and read-back wires between the controller
 * end and the memory end. assumes both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface mrt_link_if;
	import mrt_pkg::*;
	mrt_cmd_type cmd;   // command, DES when idle
	logic [5:0] ma;     // mode register address
	logic [7:0] op;     // write operand
	logic [7:0] rdata;  // mode register read data
	logic rvalid;       // read data strobe
	modport ctl (output cmd, output ma, output op, input rdata, input rvalid);
	modport dev (input cmd, input ma, input op, output rdata, output rvalid);
endinterface
`default_nettype wire

// ==== logic/mrt_mem_end.sv ====
/*
 * mrt_mem_end: memory end. decodes link commands, keeps the mode
 * registers, bank state and the reference generator control.
 * assumes the controller end keeps all command spacing.
 */
`timescale 1ns/1ps
`default_nettype none
module mrt_mem_end
	import mrt_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// link
	mrt_link_if.dev link,
	// user side
	output logic bank_open_out,
	output logic high_current_mode_out,
	output logic [7:0] ca_vref_out,
	output logic [7:0] dq_vref_out
);
	// ****************************************************
	// storage
	// ****************************************************
	logic [7:0] mr_ff [NMR];  // mode register file
	logic [7:0] rdata_ff;     // read-back word
	logic rvalid_ff;          // read-back strobe
	logic bank_ff;            // bank open state
	logic hc_ff;              // generator high current mode
	logic [7:0] ca_ff;        // command bus reference setting
	logic [7:0] dq_ff;        // data bus reference setting

	assign link.rdata = rdata_ff;
	assign link.rvalid = rvalid_ff;
	assign bank_open_out = bank_ff;
	assign high_current_mode_out = hc_ff;
	assign ca_vref_out = ca_ff;
	assign dq_vref_out = dq_ff;

	// ****************************************************
	// mode register file, one flop group per entry
	// ****************************************************
	genvar i;
	generate
		for (i = 0; i < NMR; i++) begin : g_mr
			// write only on a matching address
			always_ff @(posedge ref_clk_in or posedge reset_in) begin
				if (reset_in) begin
					mr_ff[i] <= MR_RESET;
				end else if (link.cmd == MRT_MRW && link.ma == 6'(i)) begin
					mr_ff[i] <= link.op;
				end
			end
		end
	endgenerate

	// read-back the cycle after the read command; no extra bank effect
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= (link.cmd == MRT_MRR);
			if (link.cmd == MRT_MRR) begin
				rdata_ff <= mr_ff[link.ma];
			end
		end
	end

	// bank state opens on activate, closes on precharge and on read or write with precharge
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			bank_ff <= 1'b0;
		end else if (link.cmd == MRT_ACT) begin
			bank_ff <= 1'b1;
		end else if (link.cmd == MRT_PRE || link.cmd == MRT_RDA || link.cmd == MRT_WRA) begin
			bank_ff <= 1'b0; // mode register access leaves it alone
		end
	end

	// generator mode follows the control bit in both directions
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			hc_ff <= 1'b0;
		end else if (link.cmd == MRT_MRW && link.ma == MR_HC_CTRL) begin
			hc_ff <= link.op[HC_BIT];
		end
	end

	// reference settings take effect whatever the generator mode
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ca_ff <= MR_RESET;
			dq_ff <= MR_RESET;
		end else if (link.cmd == MRT_MRW) begin
			if (link.ma == MR_CA_VREF) begin
				ca_ff <= link.op;
			end
			if (link.ma == MR_DQ_VREF) begin
				dq_ff <= link.op;
			end
		end
	end
endmodule // mrt_mem_end
`default_nettype wire

// ==== logic/mrt_ctl_end.sv ====
/*
 * mrt_ctl_end: controller end. holds a user command until every spacing
 * against earlier commands is met, then puts it on the link for one cycle.
 * assumes the user holds the request stable until accept_out pulses.
 */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// ****************************************************
module mrt_ctl_end
	import mrt_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// link
	mrt_link_if.ctl link,
	// user request
	input wire logic req_valid_in,
	input wire mrt_cmd_type req_cmd_in,
	input wire logic [5:0] req_ma_in,
	input wire logic [7:0] req_op_in,
	input wire logic odt_en_in,
	output logic accept_out,
	// user read-back
	output logic [7:0] mrr_data_out,
	output logic mrr_valid_out
);
	// ****************************************************
	// state
	// ****************************************************
	mrt_cmd_type cmd_ff;           // command on the link
	logic [5:0] ma_ff;             // address on the link
	logic [7:0] op_ff;             // operand on the link
	logic accept_ff;               // one-cycle accept pulse
	logic [7:0] mrr_data_ff;       // captured read-back
	logic mrr_valid_ff;            // read-back strobe to user
	logic [CNT_W-1:0] age_ff [NKIND]; // cycles since each command kind
	logic hc_ff;                   // our copy of the control bit
	logic [CNT_W-1:0] hc_hold_ff;  // deselect-only countdown
	logic [NKIND-1:0] ok;          // per-kind spacing met
	logic [NKIND-1:0] hit;         // which kind is on the link now
	logic go;                      // request issues this cycle

	assign link.cmd = cmd_ff;
	assign link.ma = ma_ff;
	assign link.op = op_ff;
	assign accept_out = accept_ff;
	assign mrr_data_out = mrr_data_ff;
	assign mrr_valid_out = mrr_valid_ff;

	// ****************************************************
	// spacing lookup
	// ****************************************************
	// least cycles from an earlier command of kind k to the command c
	function automatic int gap_f(input int k, input mrt_cmd_type c, input logic odt);
		int g;
		g = 0;
		case (k)
			K_MRR: begin
				case (c)
					MRT_MRR, MRT_RD, MRT_RDA: g = TMRR_CK;
					MRT_WR, MRT_WRA: g = odt ? G_MRR_WR_ODT : G_MRR_WR;
					MRT_MRW: g = G_MRR_MRW;
					default: g = 0;
				endcase
			end
			K_MRW: begin
				case (c)
					MRT_MRW: g = TMRW_CK;
					MRT_DES: g = 0;
					default: g = TMRD_CK;
				endcase
			end
			K_RD, K_RDA: begin
				case (c)
					MRT_MRR: g = G_RD_MRR;
					MRT_MRW: g = (k == K_RDA) ? G_RDA_MRW : G_RD_MRW;
					default: g = 0;
				endcase
			end
			K_WR, K_WRA: begin
				case (c)
					MRT_MRR: g = G_WR_MRR;
					MRT_MRW: g = (k == K_WRA) ? G_WRA_MRW : G_WR_MRW;
					default: g = 0;
				endcase
			end
			K_PDX: g = (c == MRT_MRR) ? G_PDX_MRR : 0;
			default: g = 0;
		endcase
		return g;
	endfunction

	// map a link command to its history slot
	function automatic int kind_f(input mrt_cmd_type c);
		int k;
		k = -1;
		case (c)
			MRT_MRR: k = K_MRR;
			MRT_MRW: k = K_MRW;
			MRT_RD: k = K_RD;
			MRT_RDA: k = K_RDA;
			MRT_WR: k = K_WR;
			MRT_WRA: k = K_WRA;
			MRT_PDX: k = K_PDX;
			default: k = -1;
		endcase
		return k;
	endfunction

	// ****************************************************
	// per-kind age counters and checks
	// ****************************************************
	genvar k;
	generate
		for (k = 0; k < NKIND; k++) begin : g_age
			assign hit[k] = (kind_f(cmd_ff) == k);
			// the issue lands one cycle after the check, so age plus one is the gap
			assign ok[k] = (32'(age_ff[k]) + 1 >= gap_f(k, req_cmd_in, odt_en_in));

			// restart on issue, saturate so old history never wraps
			always_ff @(posedge ref_clk_in or posedge reset_in) begin
				if (reset_in) begin
					age_ff[k] <= '1; // reset counts as long ago
				end else if (hit[k]) begin
					age_ff[k] <= 8'h01;
				end else if (age_ff[k] != '1) begin
					age_ff[k] <= age_ff[k] + 8'h01;
				end
			end
		end
	endgenerate

	// every applicable spacing met and no deselect-only window open
	assign go = req_valid_in && !accept_ff && (&ok) && (hc_hold_ff == 8'h00);

	// ****************************************************
	// command issue
	// ****************************************************
	// one command per grant, DES otherwise; accept gap stops double issue
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cmd_ff <= MRT_DES;
			ma_ff <= 6'h00;
			op_ff <= 8'h00;
			accept_ff <= 1'b0;
		end else begin
			accept_ff <= go;
			if (go) begin
				cmd_ff <= req_cmd_in;
				ma_ff <= req_ma_in;
				op_ff <= req_op_in;
			end else begin
				cmd_ff <= MRT_DES;
			end
		end
	end

	// ****************************************************
	// generator mode windows
	// ****************************************************
	// a change of the control bit opens a deselect-only window
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			hc_ff <= 1'b0;
			hc_hold_ff <= 8'h00;
		end else if (cmd_ff == MRT_MRW && ma_ff == MR_HC_CTRL && op_ff[HC_BIT] != hc_ff) begin
			hc_ff <= op_ff[HC_BIT];
			// the countdown starts with the command cycle itself
			if (op_ff[HC_BIT]) begin
				hc_hold_ff <= CNT_W'(HC_EN_CK - 1);
			end else begin
				hc_hold_ff <= CNT_W'(HC_DIS_CK - 1);
			end
		end else if (hc_hold_ff != 8'h00) begin
			hc_hold_ff <= hc_hold_ff - 8'h01;
		end
	end

	// ****************************************************
	// read-back capture
	// ****************************************************
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			mrr_data_ff <= 8'h00;
			mrr_valid_ff <= 1'b0;
		end else begin
			mrr_valid_ff <= link.rvalid;
			if (link.rvalid) begin
				mrr_data_ff <= link.rdata;
			end
		end
	end
endmodule // mrt_ctl_end
`default_nettype wire

// ==== sim/mrt_checker.sv ====
/*
 * mrt_checker: spacing and read-back checks on the link between both ends.
 * assumes the signals of mrt_link_if on one clock with an active high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module mrt_checker
	import mrt_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// link
	input wire mrt_cmd_type cmd,
	input wire logic [5:0] ma,
	input wire logic [7:0] op,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	// ****************************************************
	// cycles since each command kind
	// ****************************************************
	logic [5:0] hit; // mrr, mrw, rd or rda, wr or wra, wra, pdx
	logic [7:0] age_ff [6]; // saturates at ff so reset blocks nothing
	assign hit = {cmd == MRT_PDX, cmd == MRT_WRA, cmd inside {MRT_WR, MRT_WRA},
		cmd inside {MRT_RD, MRT_RDA}, cmd == MRT_MRW, cmd == MRT_MRR};
	// one counter per kind, restarted at one the cycle after its command
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		for (int i = 0; i < 6; i++) begin
			if (reset_in) begin
				age_ff[i] <= 8'hff;
			end else if (hit[i]) begin
				age_ff[i] <= 8'h01;
			end else if (age_ff[i] != 8'hff) begin
				age_ff[i] <= age_ff[i] + 8'h01;
			end
		end
	end
	// ****************************************************
	// assertions
	// ****************************************************
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	sequence mrr_seen;
		cmd == MRT_MRR;
	endsequence
	sequence mrw_seen;
		cmd == MRT_MRW;
	endsequence
	// read-back strobe high for exactly one cycle
	sequence answer_pulse;
		rvalid ##1 !rvalid;
	endsequence
	mrr_read_gap_a: assert property (cmd inside {MRT_MRR, MRT_RD, MRT_RDA} |-> age_ff[0] >= 8'h08)
		else $error("read too soon after read-back");
	mrr_write_gap_a: assert property (cmd inside {MRT_WR, MRT_WRA} |-> age_ff[0] >= 8'h0d)
		else $error("write too soon after read-back");
	mrr_mrw_gap_a: assert property (mrw_seen |-> age_ff[0] >= 8'h12)
		else $error("mode write too soon after read-back");
	into_mrr_gap_a: assert property (mrr_seen |-> age_ff[3] >= 8'h0e && age_ff[2] >= 8'h08)
		else $error("read-back too soon after data command");
	pdx_mrr_gap_a: assert property (mrr_seen |-> age_ff[5] >= 8'h0d)
		else $error("read-back too soon after power-down exit");
	after_mrw_a: assert property (cmd != MRT_DES |-> age_ff[1] >= 8'h0a)
		else $error("command inside mode write period");
	data_mrw_gap_a: assert property (mrw_seen |-> age_ff[2] >= 8'h17 && age_ff[3] >= 8'h15)
		else $error("mode write too soon after read or write");
	wra_mrw_gap_a: assert property (mrw_seen |-> age_ff[4] >= 8'h1b)
		else $error("mode write too soon after write with precharge");
	mrr_answer_a: assert property (mrr_seen |=> answer_pulse)
		else $error("read-back strobe missing or long");
	rvalid_cause_a: assert property (rvalid |-> $past(cmd) == MRT_MRR)
		else $error("read-back strobe without read-back");
	one_cycle_cmd_a: assert property (cmd != MRT_DES |=> cmd == MRT_DES)
		else $error("command held longer than one cycle");
endmodule // mrt_checker
`default_nettype wire

// ==== sim/lpddr4_mode_reg_cmd_timing_tb.sv ====
/*
 * lpddr4_mode_reg_cmd_timing_tb: both ends joined by the link, table of
 * register cases, then spacing pairs and resets.
 * assumes the package spacing figures and a 25 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module lpddr4_mode_reg_cmd_timing_tb
	import mrt_pkg::*;
;
	// ****************************************************
	// signals
	// ****************************************************
	typedef struct packed {mrt_cmd_type cmd; logic [5:0] ma; logic [7:0] op; logic [25:0] exp;}
		mrt_row_type;
	logic ref_clk, reset, req_valid, odt_en, accept, mrr_valid, bank_open, hc;
	mrt_cmd_type req_cmd;
	logic [5:0] req_ma;
	logic [7:0] req_op, mrr_data, ca_vref, dq_vref;
	logic [25:0] snap; // bank, high current, ca ref, dq ref, read-back
	mrt_row_type rows [10];
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int last_cyc;
	assign snap = {bank_open, hc, ca_vref, dq_vref, mrr_data};
	mrt_link_if u_mrt_link_if ();
	mrt_ctl_end u_mrt_ctl_end (.ref_clk_in(ref_clk), .reset_in(reset), .link(u_mrt_link_if),
		.req_valid_in(req_valid), .req_cmd_in(req_cmd), .req_ma_in(req_ma), .req_op_in(req_op),
		.odt_en_in(odt_en), .accept_out(accept), .mrr_data_out(mrr_data),
		.mrr_valid_out(mrr_valid));
	mrt_mem_end u_mrt_mem_end (.ref_clk_in(ref_clk), .reset_in(reset), .link(u_mrt_link_if),
		.bank_open_out(bank_open), .high_current_mode_out(hc), .ca_vref_out(ca_vref),
		.dq_vref_out(dq_vref));
	mrt_checker u_mrt_checker (.ref_clk_in(ref_clk), .reset_in(reset),
		.cmd(u_mrt_link_if.cmd), .ma(u_mrt_link_if.ma), .op(u_mrt_link_if.op),
		.rdata(u_mrt_link_if.rdata), .rvalid(u_mrt_link_if.rvalid));
	// ****************************************************
	// clock, cycle count, watchdog
	// ****************************************************
	initial ref_clk = 1'b0;
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;
	// all tests need about 1000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		summarize();
	end
	// ****************************************************
	// tasks
	// ****************************************************
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// entered at a falling edge, left at the falling edge of the accept cycle
	task automatic issue(input mrt_cmd_type c, input logic [5:0] a, input logic [7:0] d);
		int n;
		n = 0;
		// let one edge pass with valid low, so a second call never drops and raises it at once
		@(negedge ref_clk);
		req_cmd = c;
		req_ma = a;
		req_op = d;
		req_valid = 1'b1;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (accept !== 1'b1 && n < 100);
		check("accept", 1, accept);
		last_cyc = cyc;
		@(negedge ref_clk);
		req_valid = 1'b0;
	endtask
	// from an idle link, issue two commands and measure their spacing
	task automatic gap(input mrt_cmd_type a, input mrt_cmd_type b, input logic odt,
		input logic [7:0] d, input int exp);
		int t;
		odt_en = odt;
		repeat (30) @(negedge ref_clk);
		issue(a, 6'h0d, d);
		t = last_cyc;
		issue(b, 6'h0d, 8'h00);
		check("gap", exp, last_cyc - t);
		$display("test gap %s to %s done", a.name(), b.name());
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ****************************************************
	// main sequence
	// ****************************************************
	initial begin
		int t;
		rows[0] = '{MRT_MRW, 6'h0c, 8'h5a, {2'b00, 8'h5a, 8'h00, 8'h00}};
		rows[1] = '{MRT_MRW, 6'h0e, 8'h3c, {2'b00, 8'h5a, 8'h3c, 8'h00}};
		rows[2] = '{MRT_ACT, 6'h00, 8'h00, {2'b10, 8'h5a, 8'h3c, 8'h00}};
		rows[3] = '{MRT_MRW, 6'h0d, 8'h08, {2'b11, 8'h5a, 8'h3c, 8'h00}};
		rows[4] = '{MRT_MRR, 6'h0c, 8'h00, {2'b11, 8'h5a, 8'h3c, 8'h5a}};
		rows[5] = '{MRT_MRW, 6'h0c, 8'ha5, {2'b11, 8'ha5, 8'h3c, 8'h5a}};
		rows[6] = '{MRT_MRW, 6'h0d, 8'h00, {2'b10, 8'ha5, 8'h3c, 8'h5a}};
		rows[7] = '{MRT_MRR, 6'h0d, 8'h00, {2'b10, 8'ha5, 8'h3c, 8'h00}};
		rows[8] = '{MRT_PRE, 6'h00, 8'h00, {2'b00, 8'ha5, 8'h3c, 8'h00}};
		rows[9] = '{MRT_MRR, 6'h0e, 8'h00, {2'b00, 8'ha5, 8'h3c, 8'h3c}};
		reset = 1'b1;
		req_valid = 1'b0;
		req_cmd = MRT_DES;
		req_ma = 6'h00;
		req_op = 8'h00;
		odt_en = 1'b0;
		repeat (10) @(negedge ref_clk);
		reset = 1'b0;
		check("reset state", 28'h0, {accept, mrr_valid, snap});
		check("idle cmd", MRT_DES, u_mrt_link_if.cmd);
		// register table: state follows each command, bank kept across mode access
		foreach (rows[i]) begin
			issue(rows[i].cmd, rows[i].ma, rows[i].op);
			repeat (2) @(negedge ref_clk);
			// user read-back strobe stands only in the third cycle after the accept edge
			check("read-back strobe", rows[i].cmd == MRT_MRR, mrr_valid);
			@(negedge ref_clk);
			check("strobe ends", 0, mrr_valid);
			check("state", rows[i].exp, snap);
		end
		$display("test rows done");
		gap(MRT_MRR, MRT_RD, 1'b0, 8'h00, 8);
		gap(MRT_MRR, MRT_RDA, 1'b0, 8'h00, 8);
		gap(MRT_MRR, MRT_WR, 1'b0, 8'h00, 13);
		gap(MRT_MRR, MRT_WRA, 1'b1, 8'h00, 14);
		gap(MRT_MRR, MRT_MRW, 1'b1, 8'h00, 18);
		gap(MRT_WR, MRT_MRR, 1'b0, 8'h00, 14);
		gap(MRT_WRA, MRT_MRR, 1'b1, 8'h00, 14);
		gap(MRT_PDX, MRT_MRR, 1'b0, 8'h00, 13);
		gap(MRT_MRW, MRT_RD, 1'b0, 8'h00, 10);
		gap(MRT_MRW, MRT_MRW, 1'b0, 8'h00, 10);
		gap(MRT_RD, MRT_MRW, 1'b0, 8'h00, 23);
		gap(MRT_RDA, MRT_MRW, 1'b0, 8'h00, 23);
		gap(MRT_WR, MRT_MRW, 1'b0, 8'h00, 21);
		gap(MRT_WRA, MRT_MRW, 1'b0, 8'h00, 27);
		gap(MRT_MRW, MRT_ACT, 1'b0, 8'h08, 10);
		gap(MRT_MRW, MRT_PRE, 1'b0, 8'h00, 10);
		gap(MRT_RD, MRT_MRR, 1'b0, 8'h00, 8);
		// largest spacing wins: the earlier write with precharge still holds the mode write
		repeat (30) @(negedge ref_clk);
		issue(MRT_WRA, 6'h00, 8'h00);
		t = last_cyc;
		issue(MRT_RD, 6'h00, 8'h00);
		issue(MRT_MRW, 6'h0c, 8'h77);
		check("largest gap", 27, last_cyc - t);
		$display("test largest gap done");
		// second reset in mid-run clears both ends
		repeat (3) @(negedge ref_clk);
		reset = 1'b1;
		repeat (2) @(negedge ref_clk);
		check("mid reset", 28'h0, {accept, mrr_valid, snap});
		reset = 1'b0;
		repeat (2) @(negedge ref_clk);
		check("idle after reset", MRT_DES, u_mrt_link_if.cmd);
		$display("test reset done");
		summarize();
	end
endmodule // lpddr4_mode_reg_cmd_timing_tb
`default_nettype wire
